// ==== cup_capture.sv ====
// Implementation choices: the AXI4-Lite register port and the address map.
`default_nettype none
// Overview of operation
// - Qualifying capture-pin event copies the 16-bit timer into result pair.
// - Mode field selects falling, rising, every 4th or 16th rising edge.
// - Every capture sets the capture interrupt flag.
// - A new capture overwrites an unread result without hold-off.
// - With pin as output, port writes changing level can cause a capture.
// - A mode change may set a spurious capture flag.
// - Prescaler counter held clear when off or not in capture mode.
// - Every reset clears the prescaler counter.
// - Direct switch between 4th and 16th modes keeps the count; false capture possible.
// - With restart enable set, shutdown status self-clears when cause ends.
// - Delay count delays active-going PWM edges by instruction cycles.
module cup_capture
  import cup_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Capture pin, three signals; oe low while driving
  input wire logic capture_pin_in,
  output logic capture_pin_out,
  output logic capture_pin_oe_n,
  // Shared timer and PWM side
  input wire logic [15:0] shared_sixteen_bit_timer,
  input wire logic shutdown_event,
  input wire logic pwm_request,
  output logic pwm_active,
  // Interrupt
  output logic irq
);
  logic [7:0] capture_unit_control;
  logic [7:0] capture_result_low;
  logic [7:0] capture_result_high;
  logic [7:0] pwm_restart_delay_control;
  logic [7:0] auto_shutdown_control;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] pin_control;
  logic [3:0] prescale_count;
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic rise_edge;
  logic fall_edge;
  logic capture_event;
  logic mode_change;
  logic pin_level;
  logic pwm_delayed;
  logic aw_held;
  logic w_held;
  cup_req_t wr_req;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [3:0] mode;

  assign mode = capture_unit_control[3:0];

  // ------------------------------------------------------------
  // Bus write channel
  // ------------------------------------------------------------
  // Address and data are taken in either order; response follows both
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_req.valid)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > ADDR_PIN_CONTROL || aw_addr[1:0] != 2'h0)
          ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready)
        && !s_axi_bvalid && !wr_req.valid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready)
        && !s_axi_bvalid && !wr_req.valid;
    end
  end

  // Only the low byte lane carries data; other lanes are ignored
  assign wr_req.valid = aw_held && w_held && !s_axi_bvalid;
  assign wr_req.addr = aw_addr;
  assign wr_req.data = w_data;

  // ------------------------------------------------------------
  // Registers written by software
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      capture_unit_control <= RESET_BYTE;
      pwm_restart_delay_control <= RESET_BYTE;
      irq_mask <= RESET_BYTE;
      pin_control <= PIN_CONTROL_RESET;
    end
    else if (wr_req.valid && w_strb[0])
    begin
      unique case (wr_req.addr)
        ADDR_CONTROL: capture_unit_control <= wr_req.data[7:0];
        ADDR_RESTART_DELAY: pwm_restart_delay_control <= wr_req.data[7:0];
        ADDR_IRQ_MASK: irq_mask <= wr_req.data[7:0];
        ADDR_PIN_CONTROL: pin_control <= wr_req.data[7:0];
        default: ;
      endcase
    end
  end

  assign mode_change = wr_req.valid && w_strb[0]
    && wr_req.addr == ADDR_CONTROL && wr_req.data[3:0] != mode;

  // ------------------------------------------------------------
  // Capture pin and edge detection
  // ------------------------------------------------------------
  // Output latch drives the pin when direction is output
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      capture_pin_out <= 1'b0;
      capture_pin_oe_n <= 1'b1;
    end
    else
    begin
      capture_pin_out <= pin_control[PIN_LATCH_BIT];
      capture_pin_oe_n <= pin_control[PIN_DIR_BIT];
    end
  end

  // Driven level loops back so port writes make edges too
  assign pin_level = capture_pin_oe_n ? capture_pin_in
    : capture_pin_out;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= pin_level;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign rise_edge = pin_sync && !pin_prev;
  assign fall_edge = !pin_sync && pin_prev;

  // ------------------------------------------------------------
  // Prescaler and capture event
  // ------------------------------------------------------------
  // Count survives a direct switch between divided settings
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prescale_count <= 4'h0;
    else if (mode != MODE_RISE4 && mode != MODE_RISE16)
      prescale_count <= 4'h0;
    else if (rise_edge)
    begin
      if (mode == MODE_RISE4 && prescale_count[1:0] == PRESCALE_WRAP4[1:0])
        prescale_count <= 4'h0;
      else
        prescale_count <= prescale_count + 4'h1;
    end
  end

  always_comb
  begin
    unique case (mode)
      MODE_FALL: capture_event = fall_edge;
      MODE_RISE: capture_event = rise_edge;
      MODE_RISE4: capture_event = rise_edge
        && prescale_count[1:0] == PRESCALE_WRAP4[1:0];
      MODE_RISE16: capture_event = rise_edge
        && prescale_count == PRESCALE_WRAP16;
      default: capture_event = 1'b0;
    endcase
  end

  // No hold-off: each event overwrites the pair whether read or not
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      capture_result_low <= RESET_BYTE;
      capture_result_high <= RESET_BYTE;
    end
    else if (capture_event)
    begin
      capture_result_low <= shared_sixteen_bit_timer[7:0];
      capture_result_high <= shared_sixteen_bit_timer[15:8];
    end
    else if (wr_req.valid && w_strb[0] && wr_req.addr == ADDR_RESULT_LOW)
      capture_result_low <= wr_req.data[7:0];
    else if (wr_req.valid && w_strb[0] && wr_req.addr == ADDR_RESULT_HIGH)
      capture_result_high <= wr_req.data[7:0];
  end

  // ------------------------------------------------------------
  // Interrupt status
  // ------------------------------------------------------------
  // Write one to clear; a capture in the same cycle wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status <= RESET_BYTE;
    else
    begin
      if (wr_req.valid && w_strb[0] && wr_req.addr == ADDR_IRQ_STATUS)
        irq_status <= irq_status & ~wr_req.data[7:0];
      if (capture_event || (mode_change && capture_unit_control != RESET_BYTE))
        irq_status[IRQ_CAPTURE_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  // ------------------------------------------------------------
  // Auto-shutdown and restart
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      auto_shutdown_control <= RESET_BYTE;
    else if (shutdown_event)
      auto_shutdown_control[SHUTDOWN_STATUS_BIT] <= 1'b1;
    else if (pwm_restart_delay_control[RESTART_BIT]
      && auto_shutdown_control[SHUTDOWN_STATUS_BIT])
      auto_shutdown_control[SHUTDOWN_STATUS_BIT] <= 1'b0;
    else if (wr_req.valid && w_strb[0] && wr_req.addr == ADDR_SHUTDOWN)
      auto_shutdown_control <= wr_req.data[7:0];
  end

  cup_delay u_delay (
    .aclk(aclk),
    .aresetn(aresetn),
    .delay_count(pwm_restart_delay_control[6:0]),
    .pwm_request(pwm_request),
    .pwm_delayed(pwm_delayed)
  );

  // Shutdown forces the output inactive until the status bit clears
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pwm_active <= 1'b0;
    else
      pwm_active <= pwm_delayed
        && !auto_shutdown_control[SHUTDOWN_STATUS_BIT];
  end

  // ------------------------------------------------------------
  // Bus read channel
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (s_axi_araddr)
          ADDR_CONTROL: s_axi_rdata <= {24'h0, capture_unit_control};
          ADDR_RESULT_LOW: s_axi_rdata <= {24'h0, capture_result_low};
          ADDR_RESULT_HIGH: s_axi_rdata <= {24'h0, capture_result_high};
          ADDR_RESTART_DELAY:
            s_axi_rdata <= {24'h0, pwm_restart_delay_control};
          ADDR_SHUTDOWN: s_axi_rdata <= {24'h0, auto_shutdown_control};
          ADDR_IRQ_STATUS: s_axi_rdata <= {24'h0, irq_status};
          ADDR_IRQ_MASK: s_axi_rdata <= {24'h0, irq_mask};
          ADDR_PIN_CONTROL: s_axi_rdata <= {24'h0, pin_control};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_capture_copies_timer : assert property (@(posedge aclk)
    disable iff (!aresetn) capture_event
    |=> {capture_result_high, capture_result_low}
      == $past(shared_sixteen_bit_timer))
    else $error("capture did not latch timer");
  a_rise_mode_edge : assert property (@(posedge aclk)
    disable iff (!aresetn) mode == MODE_RISE && rise_edge
    |-> capture_event)
    else $error("rising edge missed in rise mode");
  a_fall_mode_edge : assert property (@(posedge aclk)
    disable iff (!aresetn) mode == MODE_FALL && (rise_edge || fall_edge)
    |-> capture_event == fall_edge)
    else $error("fall mode took the wrong edge");
  a_capture_sets_flag : assert property (@(posedge aclk)
    disable iff (!aresetn) capture_event
    |=> irq_status[IRQ_CAPTURE_BIT])
    else $error("capture flag not set");
  a_flag_sticky : assert property (@(posedge aclk)
    disable iff (!aresetn) irq_status[IRQ_CAPTURE_BIT]
    && !(wr_req.valid && wr_req.addr == ADDR_IRQ_STATUS)
    |=> irq_status[IRQ_CAPTURE_BIT])
    else $error("capture flag cleared by hardware");
  a_prescale_idle : assert property (@(posedge aclk)
    disable iff (!aresetn) mode == MODE_OFF
    |=> prescale_count == 4'h0)
    else $error("prescaler not held clear");
  a_sync_two_stage : assert property (@(posedge aclk)
    disable iff (!aresetn) $rose(pin_level) ##1 pin_level
    |=> pin_sync)
    else $error("synchroniser depth wrong");
  a_restart_clears : assert property (@(posedge aclk)
    disable iff (!aresetn) pwm_restart_delay_control[RESTART_BIT]
    && auto_shutdown_control[SHUTDOWN_STATUS_BIT] && !shutdown_event
    |=> !auto_shutdown_control[SHUTDOWN_STATUS_BIT])
    else $error("shutdown status did not self-clear");
  a_irq_follows : assert property (@(posedge aclk)
    disable iff (!aresetn) |(irq_status & irq_mask) |=> irq)
    else $error("interrupt output not raised");
endmodule : cup_capture
`default_nettype wire

// ==== cup_pkg.sv ====
`default_nettype none
package cup_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h04;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h08;
  localparam logic [7:0] ADDR_RESTART_DELAY = 8'h0C;
  localparam logic [7:0] ADDR_SHUTDOWN = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_PIN_CONTROL = 8'h1C;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Pin control comes out of reset as an input
  localparam logic [7:0] PIN_CONTROL_RESET = 8'h01;
  // Capture mode field codes (low nibble of control)
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_FALL = 4'h4;
  localparam logic [3:0] MODE_RISE = 4'h5;
  localparam logic [3:0] MODE_RISE4 = 4'h6;
  localparam logic [3:0] MODE_RISE16 = 4'h7;
  localparam int RESTART_BIT = 7;
  localparam int SHUTDOWN_STATUS_BIT = 7;
  localparam int IRQ_CAPTURE_BIT = 0;
  // Pin control: bit 0 direction (1 = input), bit 1 output latch
  localparam int PIN_DIR_BIT = 0;
  localparam int PIN_LATCH_BIT = 1;
  localparam logic [3:0] PRESCALE_WRAP4 = 4'h3;
  localparam logic [3:0] PRESCALE_WRAP16 = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Delay unit: one instruction cycle is four oscillator periods
  localparam int OSC_PER_INSTR = 4;
  localparam logic [1:0] QUARTER_LAST = 2'h3;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [31:0] data;
  } cup_req_t;
endpackage : cup_pkg
`default_nettype wire

// ==== cup_delay.sv ====
`default_nettype none
module cup_delay
  import cup_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic [6:0] delay_count,
  input wire logic pwm_request,
  // Delayed waveform
  output logic pwm_delayed
);
  logic [1:0] quarter;
  logic [6:0] remaining;
  logic pending;

  // Instruction-cycle tick: one every four system clocks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      quarter <= 2'h0;
    else
      quarter <= quarter + 2'h1;
  end

  // Active-going edges wait delay_count ticks; inactive edges pass at once
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pending <= 1'b0;
      remaining <= 7'h00;
      pwm_delayed <= 1'b0;
    end
    else if (!pwm_request)
    begin
      pending <= 1'b0;
      pwm_delayed <= 1'b0;
    end
    else if (!pwm_delayed && !pending)
    begin
      if (delay_count == 7'h00)
        pwm_delayed <= 1'b1;
      else
      begin
        pending <= 1'b1;
        remaining <= delay_count;
      end
    end
    else if (pending && quarter == QUARTER_LAST)
    begin
      if (remaining == 7'h01)
      begin
        pending <= 1'b0;
        pwm_delayed <= 1'b1;
      end
      remaining <= remaining - 7'h01;
    end
  end

  a_delay_zero_pass : assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(pwm_request) && delay_count == 7'h00 && !pwm_delayed
    |=> pwm_delayed)
    else $error("zero delay did not pass edge");
  // Two or more ticks can never finish within the first four clocks
  a_delay_not_early : assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(pwm_request) && delay_count > 7'h01 && !pwm_delayed
    |=> !pwm_delayed [*4])
    else $error("active edge came too early");
endmodule : cup_delay
`default_nettype wire

// ==== cup_pin_src.sv ====
`default_nettype none
module cup_pin_src (
  // Clock
  input wire logic aclk,
  // Level presented at the capture pin
  output var logic level
);
  timeunit 1ns;
  timeprecision 1ps;
  initial level = 1'b0;
  // Each level stays three clocks so the two-flop synchroniser sees it
  task automatic drive(input logic v);
    @(posedge aclk);
    level <= v;
    repeat (3) @(posedge aclk);
  endtask : drive
endmodule : cup_pin_src
`default_nettype wire

// ==== capture_unit_pwm_restart_delay_tb_top.sv ====
`default_nettype none
module capture_unit_pwm_restart_delay_tb_top
  import cup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic src_level, pin_wire, capture_pin_out, capture_pin_oe_n;
  logic shutdown_event, pwm_request, pwm_active, irq;
  logic [15:0] tmr, ecap;
  int fail_count, comparisons, cnt, d, n;
  // Block drives the pin only while its enable is low
  assign pin_wire = capture_pin_oe_n ? src_level : capture_pin_out;

  cup_capture u_cup_capture (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .capture_pin_in(pin_wire),
    .capture_pin_out, .capture_pin_oe_n,
    .shared_sixteen_bit_timer(tmr), .shutdown_event, .pwm_request,
    .pwm_active, .irq
  );
  cup_pin_src u_cup_pin_src (.aclk, .level(src_level));

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("Counts: %0d compared, %0d failed", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic fail(input string m);
    fail_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail

  task automatic chk_val(input logic [31:0] g, e, input string m);
    comparisons++;
    if (g !== e)
      fail($sformatf("%s got %0h exp %0h", m, g, e));
  endtask : chk_val

  task automatic chk_sig(input logic g, e, input string m);
    comparisons++;
    if (g !== e)
      fail($sformatf("%s got %b exp %b", m, g, e));
  endtask : chk_sig

  // ----------------------------------------------------------------
  // Register bus master
  // ----------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [7:0] v);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 200);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k >= 200)
    begin
      fail("write stalled");
      finish_test();
    end
  endtask : axw

  task automatic axr(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 200);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k >= 200)
    begin
      fail("read stalled");
      finish_test();
    end
  endtask : axr

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    axr(a);
    chk_val(rd, {24'h000000, e}, $sformatf("reg %0h", a));
  endtask : rchk

  // ----------------------------------------------------------------
  // Capture model: one pulse, rise then fall, timer differs per half
  // ----------------------------------------------------------------
  task automatic pulse_chk(input logic [3:0] mode, input bit rdres);
    logic [15:0] t;
    bit cap;
    t = 16'($urandom);
    tmr <= t;
    u_cup_pin_src.drive(1'b1);
    repeat (2) @(posedge aclk);
    if (mode == MODE_FALL)
    begin
      rchk(ADDR_IRQ_STATUS, 8'h00);
    end
    tmr <= ~t;
    u_cup_pin_src.drive(1'b0);
    repeat (4) @(posedge aclk);
    cap = 1'b1;
    if (mode == MODE_RISE4 || mode == MODE_RISE16)
    begin
      cnt = (cnt + 1) % ((mode == MODE_RISE4) ? 4 : 16);
      cap = (cnt == 0);
    end
    if (cap)
      ecap = (mode == MODE_FALL) ? ~t : t;
    chk_sig(irq, cap, "irq");
    rchk(ADDR_IRQ_STATUS, {7'h00, cap});
    if (cap)
      axw(ADDR_IRQ_STATUS, 8'h01);
    if (rdres)
    begin
      rchk(ADDR_RESULT_LOW, ecap[7:0]);
      rchk(ADDR_RESULT_HIGH, ecap[15:8]);
    end
  endtask : pulse_chk

  task automatic run_mode(input logic [3:0] mode, input bit clean, int np);
    axw(ADDR_IRQ_MASK, 8'h00);
    if (clean)
    begin
      axw(ADDR_CONTROL, 8'h00);
      cnt = 0;
    end
    axw(ADDR_CONTROL, {4'h0, mode});
    if (!clean)
      rchk(ADDR_IRQ_STATUS, 8'h01);
    axw(ADDR_IRQ_STATUS, 8'h01);
    axw(ADDR_IRQ_MASK, 8'h01);
    for (int k = 0; k < np; k++)
      pulse_chk(mode, k % 2 == 1);
    $display("test mode %0h done", mode);
  endtask : run_mode

  initial
  begin
    repeat (100000) @(posedge aclk);
    fail("run timeout");
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] ra [6];
    logic [15:0] t;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    tmr = 16'h0000;
    ecap = 16'h0000;
    shutdown_event = 1'b0;
    pwm_request = 1'b0;
    fail_count = 0;
    comparisons = 0;
    cnt = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    void'($urandom(75));
    ra = '{ADDR_CONTROL, ADDR_RESTART_DELAY, ADDR_SHUTDOWN,
           ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_PIN_CONTROL};
    for (int i = 0; i < 6; i++)
      rchk(ra[i], (i == 5) ? PIN_CONTROL_RESET : RESET_BYTE);
    axr(8'h20);
    chk_val({rd[31:2], rsp}, {30'h0, RESP_SLVERR}, "unmapped read");
    axw(8'h02, 8'hFF);
    chk_val({30'h0, rsp}, {30'h0, RESP_SLVERR}, "misaligned write");
    // A write without the low byte lane changes nothing
    s_axi_wstrb <= 4'hE;
    axw(ADDR_IRQ_MASK, 8'hFF);
    s_axi_wstrb <= 4'hF;
    chk_val({30'h0, rsp}, {30'h0, RESP_OKAY}, "lane write");
    rchk(ADDR_IRQ_MASK, RESET_BYTE);
    $display("test reset values done");
    run_mode(MODE_FALL, 1'b1, 4);
    run_mode(MODE_RISE, 1'b1, 4);
    run_mode(MODE_RISE4, 1'b1, 9);
    run_mode(MODE_RISE16, 1'b0, 17);
    run_mode(MODE_RISE4, 1'b1, 5);
    // Pin as output: a latch write makes the edge
    axw(ADDR_IRQ_MASK, 8'h00);
    axw(ADDR_PIN_CONTROL, 8'h00);
    axw(ADDR_CONTROL, 8'h00);
    axw(ADDR_CONTROL, {4'h0, MODE_RISE});
    axw(ADDR_IRQ_STATUS, 8'h01);
    t = 16'($urandom);
    tmr <= t;
    axw(ADDR_PIN_CONTROL, 8'h02);
    repeat (5) @(posedge aclk);
    chk_sig(capture_pin_oe_n, 1'b0, "pin enable");
    chk_sig(capture_pin_out, 1'b1, "pin level");
    chk_sig(irq, 1'b0, "irq masked");
    rchk(ADDR_IRQ_STATUS, 8'h01);
    rchk(ADDR_RESULT_LOW, t[7:0]);
    rchk(ADDR_RESULT_HIGH, t[15:8]);
    axw(ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge aclk);
    chk_sig(irq, 1'b1, "irq unmasked");
    repeat (40) @(posedge aclk);
    rchk(ADDR_IRQ_STATUS, 8'h01);
    axw(ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge aclk);
    chk_sig(irq, 1'b0, "irq cleared");
    axw(ADDR_PIN_CONTROL, 8'h01);
    $display("test pin output done");
    // Shutdown with and without automatic restart
    pwm_request <= 1'b1;
    axw(ADDR_RESTART_DELAY, 8'h80);
    shutdown_event <= 1'b1;
    repeat (4) @(posedge aclk);
    rchk(ADDR_SHUTDOWN, 8'h80);
    chk_sig(pwm_active, 1'b0, "shut");
    shutdown_event <= 1'b0;
    repeat (4) @(posedge aclk);
    rchk(ADDR_SHUTDOWN, 8'h00);
    chk_sig(pwm_active, 1'b1, "auto restart");
    axw(ADDR_RESTART_DELAY, 8'h00);
    shutdown_event <= 1'b1;
    repeat (4) @(posedge aclk);
    shutdown_event <= 1'b0;
    repeat (6) @(posedge aclk);
    rchk(ADDR_SHUTDOWN, 8'h80);
    chk_sig(pwm_active, 1'b0, "held shut");
    axw(ADDR_SHUTDOWN, 8'h00);
    repeat (4) @(posedge aclk);
    chk_sig(pwm_active, 1'b1, "manual restart");
    $display("test shutdown done");
    // Delay of the active-going edge, measured in clocks
    // At least two ticks, so the early-edge check has work to do
    d = 2 + $urandom % 5;
    axw(ADDR_RESTART_DELAY, {1'b0, 7'(d)});
    rchk(ADDR_RESTART_DELAY, {1'b0, 7'(d)});
    pwm_request <= 1'b0;
    repeat (30) @(posedge aclk);
    chk_sig(pwm_active, 1'b0, "pwm low");
    pwm_request <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end while (pwm_active !== 1'b1 && n < 100);
    chk_sig(n >= (d - 1) * 4 + 1 && n <= d * 4 + 3, 1'b1, "delay");
    $display("test delay %0d done after %0d clocks", d, n);
    finish_test();
  end
endmodule : capture_unit_pwm_restart_delay_tb_top
`default_nettype wire
